// ### logic/vic_top.sv
// How it works
// - Vector address from fixed slot, alt plus 0x100
// - Hardware sets flag, software clears it
// - Enable bit gates each source
// - Three-bit priority for user sources 0 to 71; later sources fixed at level 0
// - Latch winning vector and level
// - Bits allocated in request order
// - Status word bits 7:5 hold level
// - Level msb read-only to software
// - Level is msb over status bits
// - Level seven blocks user interrupts
// - Msb set allows traps only
// - Nesting disable makes status level bits read-only to software
// - Control one: nesting disable, trap flags
// - Control two: edge polarity, table select
// - Thirty-three interrupt registers in map
// - Equal priority: lower vector wins
// - Alternate table select moves all vectors
// - Nesting disabled: no preemption except by traps
// - Polarity one falling, zero rising
//
// The APB slave port and the register addresses were left to the implementer.
`include "vic_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module vic_top #(
  parameter int NSRC = 118,
  parameter int NEXT = 5
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sources
  input wire logic [NSRC-1:0] periph_req,
  input wire logic [NEXT-1:0] ext_pin,
  input wire logic [NEXT*7-1:0] ext_src_idx,
  input wire logic [4:0] trap_event,
  // CPU side
  input wire logic cpu_ack,
  input wire logic cpu_return,
  input wire logic [2:0] cpu_ipl_load,
  input wire logic cpu_ipl_load_en,
  output logic irq_valid,
  output logic [6:0] irq_vector,
  output logic [23:0] irq_address,
  output logic [3:0] cpu_priority_level
);
  import vic_pkg::*;

  // Refuse sizes the register map cannot serve
  if (NSRC > 118 || NSRC < 1 || NEXT > 5 || NEXT < 1) begin : g_bad_size
    $error("vic_top: unsupported size");
  end

  localparam int NW = 8;
  localparam int NP = 18;

  typedef struct packed {
    vic_apb_e apb;
    logic [31:0] rdata;
    vic_word_t ctl1;
    vic_word_t ctl2;
    logic [NW*16-1:0] flag;
    logic [NW*16-1:0] en;
    logic [NP*24-1:0] pri;
    vic_word_t sr;
    logic priority_level_msb;
    logic in_service;
    logic [NEXT-1:0] pin_q;
    vic_vec_t vec;
    vic_lvl_t lvl;
    logic valid;
    logic [23:0] addr;
  } vic_state_s;

  vic_state_s s_q, s_d;
  vic_arb_if #(.N(NSRC)) arb ();

  vic_arbiter #(.N(NSRC)) u_arb (.a(arb.arb));

  // ==========================================================
  // Helpers
  logic [3:0] cur_ipl;
  logic [4:0] trap_any;
  logic [2:0] trap_num;
  logic [NEXT-1:0] edge_hit;
  logic [NSRC-1:0] set_vec;
  logic acc, wr;
  logic [5:0] widx;

  assign cur_ipl = {s_q.priority_level_msb, s_q.sr[`VIC_IPL_HI:`VIC_IPL_LO]};
  assign trap_any = trap_event;
  assign acc = psel && penable;
  // Write lands at the access edge, while pready stands
  assign wr = acc && pwrite && (s_q.apb == VIC_ACK);
  assign widx = paddr[7:2];

  // Priorities packed 3 bits per source, 4 sources per word
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_src
      assign arb.req[g] = s_q.flag[g] && s_q.en[g];
      // Sources past the priority words never win: level 0 is never above the CPU
      if (g < NP*4) begin : g_pri
        assign arb.pri[3*g +: 3] = s_q.pri[24*(g/4) + 4*(g%4) +: 3];
      end else begin : g_nopri
        assign arb.pri[3*g +: 3] = 3'h0;
      end
    end
    for (g = 0; g < NEXT; g++) begin : g_ext
      // Polarity one falls, zero rises
      assign edge_hit[g] = s_q.ctl2[g] ? (s_q.pin_q[g] && !ext_pin[g])
                                      : (!s_q.pin_q[g] && ext_pin[g]);
    end
  endgenerate

  always_comb begin
    set_vec = periph_req;
    for (int k = 0; k < NEXT; k++) begin
      if (edge_hit[k] && int'(ext_src_idx[7*k +: 7]) < NSRC) begin
        set_vec[ext_src_idx[7*k +: 7]] = 1'b1;
      end
    end
  end

  // Lowest numbered trap first
  always_comb begin
    trap_num = 3'h0;
    for (int t = 4; t >= 0; t--) begin
      if (trap_any[t]) begin
        trap_num = 3'(t + 1);
      end
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.pin_q = ext_pin;
    // Set wins over software clear: writes first, events after
    if (wr) begin
      if (paddr == `VIC_OFF_CTL1) begin
        s_d.ctl1 = pwdata[15:0] & `VIC_CTL1_WMASK;
      end else if (paddr == `VIC_OFF_CTL2) begin
        s_d.ctl2 = pwdata[15:0] & `VIC_CTL2_WMASK;
      end else if (paddr >= `VIC_OFF_FLAG0 && paddr < `VIC_OFF_EN0) begin
        s_d.flag[16*(widx-6'd2) +: 16] = pwdata[15:0];
      end else if (paddr >= `VIC_OFF_EN0 && paddr < `VIC_OFF_PRI0) begin
        s_d.en[16*(widx-6'd7) +: 16] = pwdata[15:0];
      end else if (paddr >= `VIC_OFF_PRI0 && paddr < `VIC_OFF_PEND) begin
        for (int q = 0; q < 4; q++) begin
          s_d.pri[24*(widx-6'd12) + 4*q +: 3] = pwdata[4*q +: 3];
        end
      end else if (paddr == `VIC_OFF_STAT) begin
        s_d.sr[7:0] = {s_q.sr[7:5], pwdata[4:0]};
        if (!s_q.ctl1[`VIC_NEST_DIS_BIT]) begin
          s_d.sr[`VIC_IPL_HI:`VIC_IPL_LO] = pwdata[7:5];
        end
        s_d.sr[15:8] = pwdata[15:8];
      end
      // Core word: level msb not writable here
    end
    s_d.flag[NSRC-1:0] = s_d.flag[NSRC-1:0] | set_vec;
    // Status bits: dma 5, math 4, address 3, stack 2, osc 1
    s_d.ctl1[5:1] = s_d.ctl1[5:1]
                  | {trap_any[4], trap_any[3], trap_any[1], trap_any[2], trap_any[0]};
    if (cpu_ipl_load_en) begin
      s_d.sr[`VIC_IPL_HI:`VIC_IPL_LO] = cpu_ipl_load;
    end
    if (cpu_return) begin
      s_d.in_service = 1'b0;
      s_d.priority_level_msb = 1'b0;
    end
    // Presentation
    s_d.valid = 1'b0;
    if (trap_num != 3'h0) begin
      s_d.valid = 1'b1; // traps pass any level
      s_d.vec = 7'(trap_num);
      s_d.lvl = 4'hF;
    end else if (arb.found && !s_q.priority_level_msb
                 && s_q.sr[`VIC_IPL_HI:`VIC_IPL_LO] != 3'h7
                 && {1'b0, arb.lvl} > cur_ipl
                 && !(s_q.ctl1[`VIC_NEST_DIS_BIT] && s_q.in_service)) begin
      s_d.valid = 1'b1;
      s_d.vec = `VIC_USER_VEC_BASE + arb.idx;
      s_d.lvl = {1'b0, arb.lvl};
    end
    s_d.addr = `VIC_PRI_TABLE_BASE + 24'({s_d.vec, 1'b0})
             + (s_q.ctl2[`VIC_ALT_SEL_BIT] ? `VIC_ALT_TABLE_OFS : 24'h0);
    if (cpu_ack && s_q.valid) begin
      s_d.in_service = 1'b1;
      s_d.sr[`VIC_IPL_HI:`VIC_IPL_LO] = s_q.lvl[2:0];
      s_d.priority_level_msb = s_q.lvl[3];
    end
    // Read path
    if (paddr == `VIC_OFF_CTL1) begin
      s_d.rdata = {16'h0, s_q.ctl1};
    end else if (paddr == `VIC_OFF_CTL2) begin
      s_d.rdata = {16'h0, s_q.ctl2};
    end else if (paddr >= `VIC_OFF_FLAG0 && paddr < `VIC_OFF_EN0) begin
      s_d.rdata = {16'h0, s_q.flag[16*(widx-6'd2) +: 16]};
    end else if (paddr >= `VIC_OFF_EN0 && paddr < `VIC_OFF_PRI0) begin
      s_d.rdata = {16'h0, s_q.en[16*(widx-6'd7) +: 16]};
    end else if (paddr >= `VIC_OFF_PRI0 && paddr < `VIC_OFF_PEND) begin
      s_d.rdata = 32'h0;
      for (int q = 0; q < 4; q++) begin
        s_d.rdata[4*q +: 3] = s_q.pri[24*(widx-6'd12) + 4*q +: 3];
      end
    end else if (paddr == `VIC_OFF_PEND) begin
      s_d.rdata = {20'h0, s_q.lvl, 1'b0, s_q.vec};
    end else if (paddr == `VIC_OFF_STAT) begin
      s_d.rdata = {16'h0, s_q.sr};
    end else if (paddr == `VIC_OFF_CORE) begin
      s_d.rdata = {28'h0, s_q.priority_level_msb, 3'h0};
    end else begin
      s_d.rdata = 32'h0;
    end
    case (s_q.apb)
      VIC_IDLE: begin
        if (psel && !penable) begin
          s_d.apb = VIC_ACK;
        end
      end
      VIC_ACK: begin
        s_d.apb = VIC_IDLE;
      end
      default: s_d.apb = VIC_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign pready = (s_q.apb == VIC_ACK);
  assign pslverr = 1'b0;
  assign prdata = s_q.rdata;
  assign irq_valid = s_q.valid;
  assign irq_vector = s_q.vec;
  assign irq_address = s_q.addr;
  assign cpu_priority_level = cur_ipl;
endmodule : vic_top
`default_nettype wire

// ### shared/vic_defines.svh
`ifndef VIC_DEFINES_SVH
`define VIC_DEFINES_SVH

// ==========================================================
// Register byte addresses (word per register, 33 registers)
`define VIC_OFF_CTL1 12'h000
`define VIC_OFF_CTL2 12'h004
`define VIC_OFF_FLAG0 12'h008
`define VIC_OFF_EN0 12'h01C
`define VIC_OFF_PRI0 12'h030
`define VIC_OFF_PEND 12'h078
`define VIC_OFF_STAT 12'h07C
`define VIC_OFF_CORE 12'h080
// ==========================================================
// Field positions
`define VIC_NEST_DIS_BIT 15
`define VIC_ALT_SEL_BIT 15
`define VIC_IPL_LO 5
`define VIC_IPL_HI 7
`define VIC_PRIORITY_LEVEL_MSB_BIT 3
// ==========================================================
// Masks of writable bits
`define VIC_CTL1_WMASK 16'hFFFE
`define VIC_CTL2_WMASK 16'h801F
// ==========================================================
// Vector layout
`define VIC_USER_VEC_BASE 7'h08
`define VIC_PRI_TABLE_BASE 24'h000004
`define VIC_ALT_TABLE_OFS 24'h000100
`define VIC_TRAP_FIRST 3'h1
`define VIC_TRAP_LAST 3'h5
`define VIC_SR_RESET 16'h0000

`endif

// ### shared/vic_pkg.sv
package vic_pkg;
  typedef logic [15:0] vic_word_t;
  typedef logic [6:0] vic_vec_t;
  typedef logic [3:0] vic_lvl_t;
  typedef enum logic [1:0] {VIC_IDLE, VIC_ACK} vic_apb_e;
endpackage : vic_pkg

// ### shared/vic_arb_if.sv
`timescale 1ns/10ps
`default_nettype none
interface vic_arb_if #(parameter int N = 118);
  logic [N-1:0] req;
  logic [3*N-1:0] pri;
  logic found;
  logic [6:0] idx;
  logic [2:0] lvl;
  modport arb (input req, input pri, output found, output idx, output lvl);
  modport top (output req, output pri, input found, input idx, input lvl);
endinterface : vic_arb_if
`default_nettype wire

// ### logic/vic_arbiter.sv
`timescale 1ns/10ps
`default_nettype none
module vic_arbiter #(
  parameter int N = 118
) (
  // Candidates
  vic_arb_if.arb a
);
  // ==========================================================
  // Highest priority; ties to lowest index
  always_comb begin
    a.found = 1'b0;
    a.idx = 7'h00;
    a.lvl = 3'h0;
    for (int i = 0; i < N; i++) begin
      if (a.req[i] && (!a.found || a.pri[3*i +: 3] > a.lvl)) begin
        a.found = 1'b1;
        a.idx = 7'(i);
        a.lvl = a.pri[3*i +: 3];
      end
    end
  end
endmodule : vic_arbiter
`default_nettype wire

// ### dv/vic_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module vic_cpu_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Presentation
  input wire logic ack_on,
  input wire logic irq_valid,
  output logic cpu_ack
);
  // Same-cycle ack: a one-cycle trap presentation must be taken while it stands
  assign cpu_ack = presetn && ack_on && irq_valid;
endmodule : vic_cpu_model
`default_nettype wire

// ### dv/vic_top_chk.sv
`timescale 1ns/10ps
`default_nettype none
module vic_top_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // CPU side
  input wire logic cpu_ack,
  input wire logic cpu_return,
  input wire logic [2:0] cpu_ipl_load,
  input wire logic cpu_ipl_load_en,
  input wire logic irq_valid,
  input wire logic [6:0] irq_vector,
  input wire logic [23:0] irq_address,
  input wire logic [3:0] cpu_priority_level
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Register access
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  property p_rdy;
    s_setup |=> s_done;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no wait-free access");
  // ==========================================================
  // Presentation
  property p_addr;
    irq_valid |-> irq_address[7:0] == 8'({irq_vector, 1'h0} + 8'h04) && irq_address[23:9] == 0;
  endproperty
  a_addr: assert property (p_addr) else $error("vector address off slot");
  property p_trap;
    irq_valid && irq_vector < 7'h08 |-> irq_vector inside {[1:5]};
  endproperty
  a_trap: assert property (p_trap) else $error("reserved trap vector");
  property p_msb;
    irq_valid && $past(cpu_priority_level[3]) && $past(cpu_priority_level[3], 2)
      |-> irq_vector < 7'h08;
  endproperty
  a_msb: assert property (p_msb) else $error("user irq above level 7");
  property p_seven;
    irq_valid && $past(cpu_priority_level) == 4'h7 && $past(cpu_priority_level, 2) == 4'h7
      |-> irq_vector < 7'h08;
  endproperty
  a_seven: assert property (p_seven) else $error("user irq at level 7");
  // ==========================================================
  // Level
  property p_load;
    cpu_ipl_load_en && !cpu_ack && !cpu_return |=> cpu_priority_level[2:0] == $past(cpu_ipl_load);
  endproperty
  a_load: assert property (p_load) else $error("level load lost");
  property p_ret;
    cpu_return && !cpu_ack |=> !cpu_priority_level[3];
  endproperty
  a_ret: assert property (p_ret) else $error("level msb kept");
  property p_ack;
    cpu_ack && irq_valid && irq_vector < 7'h08 |-> ##[1:2] cpu_priority_level == 4'hF;
  endproperty
  a_ack: assert property (p_ack) else $error("trap level not 15");
endmodule : vic_top_chk
bind vic_top vic_top_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .cpu_ack, .cpu_return,
  .cpu_ipl_load, .cpu_ipl_load_en, .irq_valid, .irq_vector, .irq_address, .cpu_priority_level);
`default_nettype wire

// ### dv/vic_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module vic_top_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ack_on = 0;
  logic cpu_return = 0, cpu_ipl_load_en = 0, pready, pslverr, irq_valid, cpu_ack;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd_q;
  logic [117:0] periph_req = 0;
  logic [4:0] ext_pin = 0, trap_event = 0;
  logic [2:0] cpu_ipl_load = 0;
  logic [6:0] irq_vector;
  logic [23:0] irq_address;
  logic [3:0] cpu_priority_level;
  int err_total = 0, checked = 0;
  always #10 pclk = ~pclk;
  vic_top dut (.pclk, .presetn, .clk_en(1'h1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .periph_req, .ext_pin, .ext_src_idx(35'h0), .trap_event,
    .cpu_ack, .cpu_return, .cpu_ipl_load, .cpu_ipl_load_en, .irq_valid, .irq_vector,
    .irq_address, .cpu_priority_level);
  vic_cpu_model cpu (.pclk, .presetn, .ack_on, .irq_valid, .cpu_ack);
  task automatic summarize();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  // ==========================================================
  // APB master; pready and read data taken at the rising edge only
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      err_total++;
      summarize();
    end
    rd_q = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : xfer
  task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    chk(n, rd_q, e);
  endtask : rd
  task automatic pres(input logic v, input logic [6:0] c, input logic [23:0] ad,
    input logic [3:0] l);
    int n;
    for (n = 0; n < 10; n++) begin
      @(negedge pclk);
      if (irq_valid === v) break;
    end
    chk("valid", {31'h0, irq_valid}, {31'h0, v});
    chk("level", {28'h0, cpu_priority_level}, {28'h0, l});
    if (v) begin
      chk("vector", {25'h0, irq_vector}, {25'h0, c});
      chk("address", {8'h0, irq_address}, {8'h0, ad});
    end
    @(posedge pclk);
  endtask : pres
  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd("status", 12'h07C, 32'h0);
    rd("unmapped", 12'h0FC, 32'h0);
    xfer(1'h1, 12'h05C, 32'h5500);
    xfer(1'h1, 12'h024, 32'hC000);
    periph_req[47:46] <= 2'h3;
    @(posedge pclk) periph_req <= '0;
    pres(1'h1, 7'h36, 24'h70, 4'h0);
    rd("flags", 12'h010, 32'hC000);
    rd("pending", 12'h078, 32'h536);
    rd("prio", 12'h05C, 32'h5500);
    xfer(1'h1, 12'h004, 32'h8000);
    pres(1'h1, 7'h36, 24'h170, 4'h0);
    xfer(1'h1, 12'h07C, 32'hA0);
    pres(1'h0, 7'h0, 24'h0, 4'h5);
    xfer(1'h1, 12'h07C, 32'h80);
    pres(1'h1, 7'h36, 24'h170, 4'h4);
    xfer(1'h1, 12'h05C, 32'h7700);
    xfer(1'h1, 12'h07C, 32'hE0);
    pres(1'h0, 7'h0, 24'h0, 4'h7);
    xfer(1'h1, 12'h000, 32'h8000);
    xfer(1'h1, 12'h07C, 32'h0);
    rd("frozen", 12'h07C, 32'hE0);
    rd("ctl1", 12'h000, 32'h8000);
    xfer(1'h1, 12'h000, 32'h0);
    cpu_ipl_load_en <= 1'h1;
    cpu_ipl_load <= 3'h2;
    @(posedge pclk) cpu_ipl_load_en <= 1'h0;
    pres(1'h1, 7'h36, 24'h170, 4'h2);
    xfer(1'h1, 12'h024, 32'h0);
    pres(1'h0, 7'h0, 24'h0, 4'h2);
    xfer(1'h1, 12'h010, 32'h0);
    rd("cleared", 12'h010, 32'h0);
    ack_on <= 1'h1;
    trap_event <= 5'h01;
    @(posedge pclk) trap_event <= 5'h00;
    pres(1'h1, 7'h01, 24'h106, 4'h2);
    pres(1'h0, 7'h0, 24'h0, 4'hF);
    xfer(1'h1, 12'h080, 32'h0);
    rd("core", 12'h080, 32'h8);
    rd("trapflag", 12'h000, 32'h2);
    cpu_return <= 1'h1;
    @(posedge pclk) cpu_return <= 1'h0;
    rd("core", 12'h080, 32'h0);
    for (int p = 0; p < 2; p++) begin
      xfer(1'h1, 12'h004, 32'h8000 | p);
      xfer(1'h1, 12'h008, 32'h0);
      ext_pin <= {4'h0, p == 0};
      repeat (3) @(posedge pclk);
      rd("edge", 12'h008, 32'h1);
    end
    summarize();
  end
endmodule : vic_top_tb
`default_nettype wire
